// ==== inc/cmt_pkg.sv ====
// Shared constants and types for the compare-match output timer
package cmt_pkg;

   // Register bus widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Register addresses
   localparam logic [15:0] ADDR_CONTROL    = 16'hff81;
   localparam logic [15:0] ADDR_IO_CONTROL = 16'hff84;
   localparam logic [15:0] ADDR_COUNT      = 16'hff86;
   localparam logic [15:0] ADDR_COMPARE_A  = 16'hff88;
   localparam logic [15:0] ADDR_COMPARE_B  = 16'hff8a;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'hff8c;
   localparam logic [15:0] ADDR_IRQ_MASK   = 16'hff8e;

   // Field positions
   localparam int unsigned IO_A_LSB       = 0;
   localparam int unsigned IO_B_LSB       = 4;
   localparam int unsigned ACTION_W       = 3;
   localparam int unsigned CTL_INIT_A_BIT = 0;
   localparam int unsigned CTL_INIT_B_BIT = 1;
   localparam int unsigned CTL_CLEAR_BIT  = 7;
   localparam int unsigned IRQ_A_BIT      = 0;
   localparam int unsigned IRQ_B_BIT      = 1;
   localparam int unsigned IRQ_W          = 2;

   // Reset values
   localparam logic [7:0]  RST_CONTROL    = 8'h00;
   localparam logic [7:0]  RST_IO_CONTROL = 8'h00;
   localparam logic [15:0] RST_COUNT      = 16'h0000;
   localparam logic [15:0] RST_COMPARE    = 16'hffff;
   localparam logic [1:0]  RST_IRQ        = 2'h0;

   // Output actions on a compare match
   localparam logic [2:0] ACT_NONE       = 3'h0;
   localparam logic [2:0] ACT_DRIVE_LOW  = 3'h1;
   localparam logic [2:0] ACT_DRIVE_HIGH = 3'h2;
   localparam logic [2:0] ACT_TOGGLE     = 3'h3;

   // Counter clock is the system clock divided by this
   localparam int unsigned PRESCALE_DIV = 2;

   // Prescaler phase, Gray along its cycle
   typedef enum logic [0:0] {
      PH_EVEN = 1'b0,
      PH_ODD  = 1'b1
   } phase_t;

   // Per-channel configuration carried to a compare channel
   typedef struct packed {
      logic [2:0] action;
      logic       init_level;
   } chan_cfg_t;

   // Pin level after a match for a given action
   function automatic logic action_level(input logic [2:0] act, input logic cur);
      unique case (act)
         ACT_DRIVE_LOW:  action_level = 1'b0;
         ACT_DRIVE_HIGH: action_level = 1'b1;
         ACT_TOGGLE:     action_level = ~cur;
         default:        action_level = cur;
      endcase
   endfunction : action_level

endpackage : cmt_pkg

// ==== hw/cmt_prescaler.sv ====
// Divide-by-two tick for the timer counter
`timescale 1ns/1ps
module cmt_prescaler
   import cmt_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   output logic      o_tick
);

   typedef struct packed {
      phase_t phase;
   } pre_state_t;

   pre_state_t state_q;
   pre_state_t state_d;

   // Advance the phase every clock
   always_comb
   begin
      state_d = state_q;
      unique case (state_q.phase)
         PH_EVEN: state_d.phase = PH_ODD;
         PH_ODD:  state_d.phase = PH_EVEN;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         state_q <= '{phase: PH_EVEN};
      else
         state_q <= state_d;
   end

   // Rising edge of the divided clock
   assign o_tick = (state_q.phase == PH_ODD);

   AST_TICK_HALF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_tick |=> !o_tick ##1 o_tick)
      else $error("Prescaler tick not every second clock");

endmodule : cmt_prescaler

// ==== hw/cmt_channel.sv ====
// One compare channel: match detect and output pin level
`timescale 1ns/1ps
module cmt_channel
   import cmt_pkg::*;
#(
   parameter int unsigned CNT_W = 16
)
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   input  wire logic             i_tick,
   input  wire logic [CNT_W-1:0] i_count,
   input  wire logic [CNT_W-1:0] i_compare,
   input  wire chan_cfg_t        i_cfg,
   input  wire logic             i_reinit,
   output logic                  o_match,
   output logic                  o_pin
);

   typedef struct packed {
      logic pin;
   } chan_state_t;

   chan_state_t state_q;
   chan_state_t state_d;

   // Match once per counter value, at its advance
   assign o_match = i_tick && (i_count == i_compare);

   // Reinit loads initial level, match applies action, else hold
   always_comb
   begin
      state_d = state_q;
      if (i_reinit)
         state_d.pin = i_cfg.init_level;
      else if (o_match)
         state_d.pin = action_level(i_cfg.action, state_q.pin);
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         state_q <= '{pin: 1'b0};
      else
         state_q <= state_d;
   end

   assign o_pin = state_q.pin;

endmodule : cmt_channel

// ==== hw/cmt_timer.sv ====
// Top of the compare-match output timer with its register file
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module cmt_timer
   import cmt_pkg::*;
#(
   parameter int unsigned CNT_W = 16
)
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [DATA_W-1:0]      o_rd_data,
   output logic                   o_compare_pin_a,
   output logic                   o_compare_pin_b,
   output logic                   o_irq
);

   // Registers hold the counter at its full documented width
   if (CNT_W != DATA_W)
   begin : g_bad_width
      $error("CNT_W must equal the 16-bit register width");
   end

   typedef struct packed {
      logic [7:0]       control;
      logic [7:0]       io_control;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] compare_a;
      logic [CNT_W-1:0] compare_b;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [DATA_W-1:0] rd_data;
      logic             reinit;
   } tmr_state_t;

   tmr_state_t state_q;
   tmr_state_t state_d;

   logic      tick;
   logic      match_a;
   logic      match_b;
   chan_cfg_t cfg_a;
   chan_cfg_t cfg_b;
   logic      wr_count;
   logic      clear_on_match_a;

   // Counter clock
   cmt_prescaler u_prescaler (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .o_tick    (tick)
   );

   // Channel configuration from the control registers
   always_comb
   begin
      cfg_a.action     = state_q.io_control[IO_A_LSB +: ACTION_W];
      cfg_a.init_level = state_q.control[CTL_INIT_A_BIT];
      cfg_b.action     = state_q.io_control[IO_B_LSB +: ACTION_W];
      cfg_b.init_level = state_q.control[CTL_INIT_B_BIT];
   end

   // Channel A, drives low on match with action 001
   cmt_channel #(
      .CNT_W (CNT_W)
   ) u_chan_a (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_tick    (tick),
      .i_count   (state_q.count),
      .i_compare (state_q.compare_a),
      .i_cfg     (cfg_a),
      .i_reinit  (state_q.reinit),
      .o_match   (match_a),
      .o_pin     (o_compare_pin_a)
   );

   // Channel B, drives high on match with action 010
   cmt_channel #(
      .CNT_W (CNT_W)
   ) u_chan_b (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_tick    (tick),
      .i_count   (state_q.count),
      .i_compare (state_q.compare_b),
      .i_cfg     (cfg_b),
      .i_reinit  (state_q.reinit),
      .o_match   (match_b),
      .o_pin     (o_compare_pin_b)
   );

   assign wr_count         = i_wr && (i_addr == ADDR_COUNT);
   assign clear_on_match_a = state_q.control[CTL_CLEAR_BIT];

   // Register file, counter, event flags and read path
   always_comb
   begin
      state_d         = state_q;
      state_d.reinit  = 1'b0;
      state_d.rd_data = '0;

      // Counter: software write wins, then clear, then increment
      if (wr_count)
         state_d.count = i_wr_data[CNT_W-1:0];
      else if (match_a && clear_on_match_a)
         state_d.count = '0;
      else if (tick)
         state_d.count = state_q.count + 1'b1;

      // Register writes
      if (i_wr)
      begin
         unique case (i_addr)
            ADDR_CONTROL:
            begin
               state_d.control = i_wr_data[7:0];
               state_d.reinit  = 1'b1;
            end
            ADDR_IO_CONTROL: state_d.io_control = i_wr_data[7:0];
            ADDR_COMPARE_A:  state_d.compare_a  = i_wr_data[CNT_W-1:0];
            ADDR_COMPARE_B:  state_d.compare_b  = i_wr_data[CNT_W-1:0];
            ADDR_IRQ_MASK:   state_d.irq_mask   = i_wr_data[IRQ_W-1:0];
            default:         state_d.reinit     = 1'b0;
         endcase
      end

      // Reads: data in the following cycle only, status cleared by read
      if (i_rd)
      begin
         unique case (i_addr)
            ADDR_CONTROL:    state_d.rd_data = {8'h00, state_q.control};
            ADDR_IO_CONTROL: state_d.rd_data = {8'h00, state_q.io_control};
            ADDR_COUNT:      state_d.rd_data = state_q.count;
            ADDR_COMPARE_A:  state_d.rd_data = state_q.compare_a;
            ADDR_COMPARE_B:  state_d.rd_data = state_q.compare_b;
            ADDR_IRQ_STATUS:
            begin
               state_d.rd_data    = {14'h0000, state_q.irq_status};
               state_d.irq_status = '0;
            end
            ADDR_IRQ_MASK:   state_d.rd_data = {14'h0000, state_q.irq_mask};
            default:         state_d.rd_data = '0;
         endcase
      end

      // Match events set sticky flags; a set beats a same-cycle clear
      if (match_a)
         state_d.irq_status[IRQ_A_BIT] = 1'b1;
      if (match_b)
         state_d.irq_status[IRQ_B_BIT] = 1'b1;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state_q.control    <= RST_CONTROL;
         state_q.io_control <= RST_IO_CONTROL;
         state_q.count      <= RST_COUNT;
         state_q.compare_a  <= RST_COMPARE;
         state_q.compare_b  <= RST_COMPARE;
         state_q.irq_status <= RST_IRQ;
         state_q.irq_mask   <= RST_IRQ;
         state_q.rd_data    <= '0;
         state_q.reinit     <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Outputs
   assign o_rd_data = state_q.rd_data;
   assign o_irq     = |(state_q.irq_status & state_q.irq_mask);

   // Counter advance and hold
   sequence s_plain_tick;
      tick && !wr_count && !(match_a && clear_on_match_a);
   endsequence

   AST_COUNT_INC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_plain_tick |=> state_q.count == $past(state_q.count) + 16'h0001)
      else $error("Counter did not advance by one on a tick");

   AST_COUNT_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!tick && !wr_count) |=> $stable(state_q.count))
      else $error("Counter moved without a tick");

   AST_MATCH_A: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tick && state_q.count == state_q.compare_a) |=> state_q.irq_status[IRQ_A_BIT])
      else $error("Compare A equality did not raise match A");

   AST_MATCH_B: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (tick && state_q.count == state_q.compare_b) |=> state_q.irq_status[IRQ_B_BIT])
      else $error("Compare B equality did not raise match B");

   // Match with a given action and no reinit in the way
   sequence s_match_a_low;
      match_a && cfg_a.action == ACT_DRIVE_LOW && !state_q.reinit;
   endsequence

   sequence s_match_b_high;
      match_b && cfg_b.action == ACT_DRIVE_HIGH && !state_q.reinit;
   endsequence

   AST_PIN_A_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_match_a_low |=> !o_compare_pin_a)
      else $error("Pin A not driven low on match A");

   AST_PIN_B_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_match_b_high |=> o_compare_pin_b)
      else $error("Pin B not driven high on match B");

   AST_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (match_a && clear_on_match_a && !wr_count) |=> state_q.count == 16'h0000)
      else $error("Counter not cleared on match A");

   AST_NO_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (match_a && !clear_on_match_a && !wr_count)
         |=> state_q.count == $past(state_q.count) + 16'h0001)
      else $error("Counter cleared with clear-on-match off");

   // Control write, then reinit, then initial level on the pins
   sequence s_ctl_write;
      i_wr && i_addr == ADDR_CONTROL;
   endsequence

   AST_INIT_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_ctl_write |=> state_q.reinit ##1
         (o_compare_pin_a == $past(i_wr_data[0], 2)
          && o_compare_pin_b == $past(i_wr_data[1], 2)))
      else $error("Pins did not take the initial levels");

   AST_PIN_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!match_a && !match_b && !state_q.reinit)
         |=> $stable(o_compare_pin_a) && $stable(o_compare_pin_b))
      else $error("Pin changed without match or reinit");

   AST_IRQ_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (match_a && state_q.irq_mask[IRQ_A_BIT] && !(i_wr && i_addr == ADDR_IRQ_MASK))
         |=> o_irq)
      else $error("Unmasked match A did not raise the interrupt");

   AST_RD_ONE_CYCLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_rd |=> o_rd_data == 16'h0000)
      else $error("Read data present without a read");

   // Register writes land at the taking edge
   AST_WR_COUNT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_count |=> state_q.count == $past(i_wr_data))
      else $error("Counter write did not land");

   AST_WR_CONTROL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_ctl_write |=> state_q.control == $past(i_wr_data[7:0]))
      else $error("Control write did not land");

   AST_WR_IO_CONTROL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && i_addr == ADDR_IO_CONTROL) |=> state_q.io_control == $past(i_wr_data[7:0]))
      else $error("Action write did not land");

   AST_WR_COMPARE_A: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && i_addr == ADDR_COMPARE_A) |=> state_q.compare_a == $past(i_wr_data))
      else $error("Compare A write did not land");

   AST_WR_COMPARE_B: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && i_addr == ADDR_COMPARE_B) |=> state_q.compare_b == $past(i_wr_data))
      else $error("Compare B write did not land");

   AST_WR_MASK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && i_addr == ADDR_IRQ_MASK) |=> state_q.irq_mask == $past(i_wr_data[IRQ_W-1:0]))
      else $error("Mask write did not land");

   // Read data is the register as it stood at the read edge
   AST_RD_COUNT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_rd && i_addr == ADDR_COUNT) |=> o_rd_data == $past(state_q.count))
      else $error("Counter read returned a wrong value");

   AST_RD_COMPARE_A: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_rd && i_addr == ADDR_COMPARE_A) |=> o_rd_data == $past(state_q.compare_a))
      else $error("Compare A read returned a wrong value");

   AST_RD_COMPARE_B: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_rd && i_addr == ADDR_COMPARE_B) |=> o_rd_data == $past(state_q.compare_b))
      else $error("Compare B read returned a wrong value");

   AST_RD_CONTROL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_rd && i_addr == ADDR_CONTROL) |=> o_rd_data == {8'h00, $past(state_q.control)})
      else $error("Control read returned a wrong value");

   // Status bits are sticky until a read clears them
   sequence s_status_read;
      i_rd && i_addr == ADDR_IRQ_STATUS;
   endsequence

   AST_RD_STATUS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_status_read |=> o_rd_data == {14'h0000, $past(state_q.irq_status)})
      else $error("Status read returned a wrong value");

   AST_STATUS_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_status_read ##0 (!match_a && !match_b) |=> state_q.irq_status == RST_IRQ)
      else $error("Status not cleared by its read");

   AST_STATUS_HOLD_A: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_q.irq_status[IRQ_A_BIT] && !(i_rd && i_addr == ADDR_IRQ_STATUS))
         |=> state_q.irq_status[IRQ_A_BIT])
      else $error("Status A dropped without a read");

   AST_STATUS_HOLD_B: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_q.irq_status[IRQ_B_BIT] && !(i_rd && i_addr == ADDR_IRQ_STATUS))
         |=> state_q.irq_status[IRQ_B_BIT])
      else $error("Status B dropped without a read");

   // Toggle and no-action matches, reinit only after a control write
   sequence s_match_a_toggle;
      match_a && cfg_a.action == ACT_TOGGLE && !state_q.reinit;
   endsequence

   sequence s_match_b_none;
      match_b && cfg_b.action == ACT_NONE && !state_q.reinit;
   endsequence

   AST_PIN_A_TOGGLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_match_a_toggle |=> o_compare_pin_a != $past(o_compare_pin_a))
      else $error("Pin A did not toggle on match A");

   AST_PIN_B_NONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_match_b_none |=> $stable(o_compare_pin_b))
      else $error("Pin B moved on a no-action match");

   AST_REINIT_PULSE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !(i_wr && i_addr == ADDR_CONTROL) |=> !state_q.reinit)
      else $error("Reinit without a control write");

endmodule : cmt_timer

// ==== dv/cmt_timer_tb.sv ====
// Self-checking testbench for the compare-match output timer
`timescale 1ns/1ps
module tb;
   import cmt_pkg::*;

   logic              i_sys_clk;
   logic              i_rst;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wr_data;
   logic              i_wr;
   logic              i_rd;
   logic [DATA_W-1:0] o_rd_data;
   logic              o_compare_pin_a;
   logic              o_compare_pin_b;
   logic              o_irq;
   int                error_cnt;
   int                tests_run;
   int                seed;
   logic [DATA_W-1:0] exp_q[$];
   logic              rd_seen = 1'b0;
   logic [15:0]       rnd;

   cmt_timer #(.CNT_W(16)) DUT (
      .i_sys_clk       (i_sys_clk),
      .i_rst           (i_rst),
      .i_addr          (i_addr),
      .i_wr_data       (i_wr_data),
      .i_wr            (i_wr),
      .i_rd            (i_rd),
      .o_rd_data       (o_rd_data),
      .o_compare_pin_a (o_compare_pin_a),
      .o_compare_pin_b (o_compare_pin_b),
      .o_irq           (o_irq)
   );

   // 125 MHz system clock
   initial i_sys_clk = 1'b0;
   always #4 i_sys_clk = ~i_sys_clk;

   // Counts and verdict, then stop
   task automatic finish_test;
      $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // One comparison of a 16-bit word
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   // One comparison of a pin or interrupt level
   task automatic chk_lvl(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_lvl

   // Write strobe stays up until the next task changes it
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      i_wr      <= 1'b1;
      i_rd      <= 1'b0;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_sys_clk);
   endtask : wr

   // Read with the expected word queued for the monitor
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      exp_q.push_back(exp);
      i_rd   <= 1'b1;
      i_wr   <= 1'b0;
      i_addr <= a;
      @(posedge i_sys_clk);
   endtask : rd

   // Drop both strobes and let n edges pass
   task automatic idle(input int n);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (n) @(posedge i_sys_clk);
   endtask : idle

   // Read data is taken in the cycle after the read edge
   always @(posedge i_sys_clk)
   begin
      if (rd_seen)
         chk_word("o_rd_data", exp_q.pop_front(), o_rd_data);
      rd_seen = i_rd;
   end

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      error_cnt++;
      $display("BAD watchdog expected end seen timeout");
      finish_test();
   end

   // Main sequence
   initial
   begin
      i_rst     = 1'b1;
      i_wr      = 1'b0;
      i_rd      = 1'b0;
      i_addr    = 16'h0000;
      i_wr_data = 16'h0000;
      error_cnt = 0;
      tests_run = 0;
      seed      = 32'h8d39_e0b6;
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      idle(2);

      // Reset values, unmapped address, random readback
      rd(ADDR_CONTROL, {8'h00, RST_CONTROL});
      rd(ADDR_IO_CONTROL, {8'h00, RST_IO_CONTROL});
      rd(ADDR_COMPARE_A, RST_COMPARE);
      rd(ADDR_COMPARE_B, RST_COMPARE);
      rd(ADDR_IRQ_STATUS, {14'h0000, RST_IRQ});
      rd(ADDR_IRQ_MASK, {14'h0000, RST_IRQ});
      wr(16'hff90, 16'hffff);
      rd(16'hff90, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         rnd = 16'($random(seed));
         rnd[15] = 1'b1;
         wr(ADDR_COMPARE_A, rnd);
         rd(ADDR_COMPARE_A, rnd);
         wr(ADDR_COMPARE_B, ~rnd | 16'h8000);
         rd(ADDR_COMPARE_B, ~rnd | 16'h8000);
      end
      wr(ADDR_CONTROL, 16'hff83);
      rd(ADDR_CONTROL, 16'h0083);
      wr(ADDR_IO_CONTROL, 16'hff77);
      rd(ADDR_IO_CONTROL, 16'h0077);
      wr(ADDR_IRQ_MASK, 16'hffff);
      rd(ADDR_IRQ_MASK, 16'h0003);
      idle(2);
      $display("test registers done");

      // Count rate, wrap and clear on match A
      wr(ADDR_COMPARE_B, 16'h8000);
      wr(ADDR_COMPARE_A, 16'h0010);
      for (int clr = 0; clr < 2; clr++)
      begin
         wr(ADDR_CONTROL, clr ? 16'h0080 : 16'h0000);
         wr(ADDR_COUNT, 16'h000f);
         idle(8);
         rd(ADDR_COUNT, clr ? 16'h0002 : 16'h0013);
         wr(ADDR_COUNT, 16'hfffe);
         idle(6);
         rd(ADDR_COUNT, 16'h0001);
      end
      rd(ADDR_IRQ_STATUS, 16'h0001);
      rd(ADDR_IRQ_STATUS, 16'h0000);
      idle(2);
      $display("test counter done");

      // Pin actions, initial levels and interrupt
      wr(ADDR_COMPARE_A, 16'h4000);
      wr(ADDR_COMPARE_B, 16'h8000);
      wr(ADDR_IO_CONTROL, {9'h000, ACT_DRIVE_HIGH, 1'b0, ACT_DRIVE_LOW});
      wr(ADDR_IRQ_MASK, 16'h0001);
      wr(ADDR_COUNT, 16'h3ffc);
      wr(ADDR_CONTROL, 16'h0001);
      idle(3);
      chk_lvl("o_compare_pin_a", 1'b1, o_compare_pin_a);
      chk_lvl("o_compare_pin_b", 1'b0, o_compare_pin_b);
      chk_lvl("o_irq", 1'b0, o_irq);
      idle(8);
      chk_lvl("o_compare_pin_a", 1'b0, o_compare_pin_a);
      chk_lvl("o_compare_pin_b", 1'b0, o_compare_pin_b);
      chk_lvl("o_irq", 1'b1, o_irq);
      rd(ADDR_IRQ_STATUS, 16'h0001);
      idle(2);
      chk_lvl("o_irq", 1'b0, o_irq);
      wr(ADDR_COUNT, 16'h7ffc);
      idle(12);
      chk_lvl("o_compare_pin_b", 1'b1, o_compare_pin_b);
      chk_lvl("o_compare_pin_a", 1'b0, o_compare_pin_a);
      chk_lvl("o_irq", 1'b0, o_irq);
      rd(ADDR_IRQ_STATUS, 16'h0002);
      rd(ADDR_IRQ_STATUS, 16'h0000);
      wr(ADDR_CONTROL, 16'h0001);
      idle(3);
      chk_lvl("o_compare_pin_a", 1'b1, o_compare_pin_a);
      chk_lvl("o_compare_pin_b", 1'b0, o_compare_pin_b);
      $display("test pins done");

      // Toggle on channel A, no action on channel B, both from level 0
      wr(ADDR_IO_CONTROL, {9'h000, ACT_NONE, 1'b0, ACT_TOGGLE});
      wr(ADDR_CONTROL, 16'h0000);
      wr(ADDR_COUNT, 16'h3ffe);
      idle(8);
      chk_lvl("o_compare_pin_a", 1'b1, o_compare_pin_a);
      wr(ADDR_COUNT, 16'h7ffe);
      idle(8);
      chk_lvl("o_compare_pin_b", 1'b0, o_compare_pin_b);
      chk_lvl("o_compare_pin_a", 1'b1, o_compare_pin_a);
      chk_lvl("o_irq", 1'b1, o_irq);
      rd(ADDR_IRQ_STATUS, 16'h0003);
      idle(2);
      $display("test actions done");

      chk_word("pending reads", 16'h0000, 16'(exp_q.size()));
      finish_test();
   end

endmodule : tb
